// ==== pvcr_pkg.sv ====
package pvcr_pkg;
  // management register indices
  localparam logic [4:0] REG_ENERGY = 5'h11;
  localparam logic [4:0] REG_STRAP  = 5'h12;
  localparam logic [4:0] REG_XOVER  = 5'h1b;
  localparam logic [4:0] REG_FLAGS  = 5'h1d;
  localparam logic [4:0] REG_MASK   = 5'h1e;
  localparam logic [4:0] REG_LINK   = 5'h1f;
  // field positions
  localparam int EDPD_BIT    = 13;
  localparam int PRESENT_BIT = 1;
  localparam int MODE_LSB    = 5;
  localparam int ADDR_LSB    = 0;
  localparam int OVR_BIT     = 15;
  localparam int AMDIX_BIT   = 14;
  localparam int MDIX_BIT    = 13;
  localparam int PLL_BIT     = 10;
  localparam int POL_BIT     = 4;
  localparam int FLAG_LSB    = 1;
  localparam int DONE_BIT    = 12;
  localparam int RSV_LSB     = 5;
  localparam int SPEED_LSB   = 2;
  // values after reset
  localparam logic [4:0] ADDR_RST     = 5'h01;
  localparam logic [2:0] MODE_RST     = 3'h7;
  localparam logic [6:0] LINK_RSV_RST = 7'h02;
  localparam logic [7:0] MASK_RST     = 8'h00;
  // operating modes
  localparam logic [2:0] MODE_10H  = 3'h0;
  localparam logic [2:0] MODE_10F  = 3'h1;
  localparam logic [2:0] MODE_100H = 3'h2;
  localparam logic [2:0] MODE_100F = 3'h3;
  localparam logic [2:0] MODE_AN_H = 3'h4;
  localparam logic [2:0] MODE_REPT = 3'h5;
  localparam logic [2:0] MODE_ALL  = 3'h7;
  localparam logic [3:0] ADV_100H  = 4'h4;
  localparam logic [3:0] ADV_ALL   = 4'hf;
  // serial management frame
  localparam logic [1:0] OP_RD        = 2'h2;
  localparam logic [1:0] OP_WR        = 2'h1;
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [5:0] HDR_LAST     = 6'h0c;
  localparam logic [5:0] RD_END       = 6'h12;
  localparam logic [5:0] WR_LAST      = 6'h11;
  // timing
  localparam int ENERGY_TIMEOUT_MS  = 256;
  localparam int CLK_KHZ            = 250000;
  localparam int ENERGY_TIMEOUT_CYC = ENERGY_TIMEOUT_MS * CLK_KHZ;

  typedef struct packed {
    logic an_complete;
    logic remote_fault;
    logic link_down;
    logic partner_ack;
    logic pd_fault;
    logic page_rx;
  } pvcr_events_t;

  typedef struct packed {
    logic       autoneg_en;
    logic       speed100;
    logic       full_duplex;
    logic [3:0] adv;
    logic       crs_on_tx;
    logic       repeater;
  } pvcr_cfg_t;
endpackage : pvcr_pkg

// ==== pvcr_sticky_flag.sv ====
`timescale 1ns/10ps
module pvcr_sticky_flag (
  input  wire logic clk,   // system clock
  input  wire logic rst_n, // synchronised reset
  input  wire logic set,   // event pulse
  input  wire logic clr,   // clear pulse
  output logic      q      // latched flag
);
  typedef struct packed {
    logic flag;
  } pvcr_flag_st_t;

  pvcr_flag_st_t s_q;
  pvcr_flag_st_t s_d;

  always_comb begin
    s_d = s_q;
    // set beats clear so a coincident event survives the read
    s_d.flag = set | (s_q.flag & ~clr);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.flag;

  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    set |=> q) else $error("flag lost its event");
endmodule : pvcr_sticky_flag

// ==== pvcr_energy_timer.sv ====
`timescale 1ns/10ps
module pvcr_energy_timer #(
  parameter int CNT_W = 27,
  parameter int LIMIT = 64000000
) (
  input  wire logic clk,         // system clock
  input  wire logic rst_n,       // hardware reset only
  input  wire logic line_energy, // valid energy seen this cycle
  output logic      present      // energy present status
);
  typedef struct packed {
    logic             present;
    logic [CNT_W-1:0] cnt;
  } pvcr_tmr_st_t;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

  pvcr_tmr_st_t s_q;
  pvcr_tmr_st_t s_d;

  always_comb begin
    s_d = s_q;
    if (line_energy) begin
      s_d.cnt     = '0;
      s_d.present = 1'b1;
    end else if (s_q.present) begin
      if (s_q.cnt == LAST) begin
        s_d.present = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  // soft reset is not wired here: status survives it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{present: 1'b1, cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign present = s_q.present;

  energy_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!line_energy && s_q.present && s_q.cnt == LAST) |=> !present)
    else $error("energy status did not drop at timeout");
endmodule : pvcr_energy_timer

// ==== pvcr_regs.sv ====
// What this block does
// - Register 17 bit 13 enables energy-detect power-down; resets disabled.
// - Energy-present bit clears after 256 ms without valid line energy.
// - Hardware reset sets energy-present to 1; soft reset leaves it.
// - Register 18 holds mode 7:5 and station address 4:0, default 00001.
// - Modes 000/001 force 10 Mb/s half/full, negotiation off.
// - Modes 010/011 force 100 Mb/s half/full with matching carrier sense.
// - Modes 100/101 negotiate advertising 100 half only; 101 is repeater.
// - Mode 111 advertises everything; speed and duplex follow negotiation.
// - Register 27 bit 15 chooses strap or bits 14:13 for crossover.
// - Override with bit 14 set enables auto crossover, bit 13 kept 0.
// - Manual crossover: bit 13 swaps transmit and receive pairs.
// - Register 27 bit 10 holds the 10 Mb/s receive PLL on reference.
// - Register 27 bit 4 reads receive polarity reversal, ignores writes.
// - Register 29 latches seven event flags high until read.
// - Register 30 bits 7:1 enable each flag, bit 0 enables none; all masked after reset.
// - Register 31 bit 12 reads 1 only when negotiation has finished.
// - Register 31 bits 4:2 report resolved speed and duplex.
`timescale 1ns/10ps
module pvcr_regs #(
  parameter int ENERGY_CYCLES = pvcr_pkg::ENERGY_TIMEOUT_CYC,
  parameter int ENERGY_CNT_W  = 27
) (
  input  wire logic                clk,                   // 250 MHz
  input  wire logic                arst_n,                // async reset
  input  wire logic                soft_reset,            // soft reset pulse
  input  wire logic                mdc,                   // mgmt clock pin
  input  wire logic                mdio_in,               // mgmt data in
  output logic                     mdio_out,              // mgmt data out
  output logic                     mdio_oe,               // mgmt drive en
  input  wire logic [2:0]          mode_strap,            // mode strap
  input  wire logic                crossover_strap_input, // crossover strap
  input  wire logic                line_energy,           // energy seen
  input  wire logic                rx_polarity_reversed,  // 10M polarity
  input  wire logic                negotiation_done,      // negotiation end
  input  wire logic                res_speed100,          // negotiated 100M
  input  wire logic                res_full_duplex,       // negotiated FD
  input  wire pvcr_pkg::pvcr_events_t events,             // event pulses
  output pvcr_pkg::pvcr_cfg_t      link_cfg,              // decoded mode
  output logic                     energy_detect_powerdown_en, // power-down
  output logic                     line_energy_present,   // energy status
  output logic [4:0]               station_address,       // mgmt address
  output logic                     auto_crossover_en,     // auto crossover
  output logic                     pairs_swapped,         // manual swap
  output logic                     rx_pll_reference_lock, // PLL held
  output logic                     phy_irq                // interrupt
);
  typedef enum logic [1:0] {PH_PRE, PH_HDR, PH_RD, PH_WR} pvcr_phase_t;

  typedef struct packed {
    logic                mdc_prev;
    logic                loaded;
    logic                present_prev;
    logic                edpd;
    logic [2:0]          mode;
    logic [4:0]          addr;
    logic                ovr;
    logic                amdix;
    logic                mdix;
    logic                pll_lock;
    logic [7:0]          mask;
    logic [6:0]          link_rsv;
    pvcr_pkg::pvcr_cfg_t cfg;
    logic                xauto;
    logic                xswap;
    pvcr_phase_t         ph;
    logic [5:0]          cnt;
    logic [12:0]         hdr;
    logic [15:0]         rdata;
    logic [15:0]         wdata;
    logic                mdo;
    logic                moe;
  } pvcr_state_t;

  logic        rst_meta_q;
  logic        rst_sync_q;
  pvcr_state_t s_q;
  pvcr_state_t s_d;
  logic [12:0] hdr_in;
  logic [15:0] wr_word;
  logic [15:0] rd_word;
  logic        rise;
  logic        fall;
  logic        wr_fire;
  logic        rd_flags;
  logic        clr_flags;
  logic [6:0]  set_vec;
  logic [6:0]  flags;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  pvcr_energy_timer #(
    .CNT_W (ENERGY_CNT_W),
    .LIMIT (ENERGY_CYCLES)
  ) u_energy (
    .clk         (clk),
    .rst_n       (rst_sync_q),
    .line_energy (line_energy),
    .present     (line_energy_present)
  );

  // flag i sits at register bit i+1
  assign set_vec = {line_energy_present & ~s_q.present_prev, events};
  assign clr_flags = rd_flags | soft_reset;

  for (genvar i = 0; i < 7; i++) begin : g_flag
    pvcr_sticky_flag u_flag (
      .clk   (clk),
      .rst_n (rst_sync_q),
      .set   (set_vec[i]),
      .clr   (clr_flags),
      .q     (flags[i])
    );
  end

  assign rise    = mdc & ~s_q.mdc_prev;
  assign fall    = ~mdc & s_q.mdc_prev;
  assign hdr_in  = {s_q.hdr[11:0], mdio_in};
  assign wr_word = {s_q.wdata[14:0], mdio_in};

  // read image of the addressed register; unmapped indices read zero
  always_comb begin
    rd_word = 16'h0000;
    case (hdr_in[4:0])
      pvcr_pkg::REG_ENERGY: begin
        rd_word[pvcr_pkg::EDPD_BIT]    = s_q.edpd;
        rd_word[pvcr_pkg::PRESENT_BIT] = line_energy_present;
      end
      pvcr_pkg::REG_STRAP: begin
        rd_word[pvcr_pkg::MODE_LSB +: 3] = s_q.mode;
        rd_word[pvcr_pkg::ADDR_LSB +: 5] = s_q.addr;
      end
      pvcr_pkg::REG_XOVER: begin
        rd_word[pvcr_pkg::OVR_BIT]   = s_q.ovr;
        rd_word[pvcr_pkg::AMDIX_BIT] = s_q.amdix;
        rd_word[pvcr_pkg::MDIX_BIT]  = s_q.mdix;
        rd_word[pvcr_pkg::PLL_BIT]   = s_q.pll_lock;
        rd_word[pvcr_pkg::POL_BIT]   = rx_polarity_reversed;
      end
      pvcr_pkg::REG_FLAGS: begin
        rd_word[pvcr_pkg::FLAG_LSB +: 7] = flags;
      end
      pvcr_pkg::REG_MASK: begin
        rd_word[7:0] = s_q.mask;
      end
      pvcr_pkg::REG_LINK: begin
        rd_word[pvcr_pkg::DONE_BIT] = negotiation_done &
                                      s_q.cfg.autoneg_en;
        rd_word[pvcr_pkg::RSV_LSB +: 7] = s_q.link_rsv;
        rd_word[pvcr_pkg::SPEED_LSB +: 3] = {s_q.cfg.full_duplex,
          s_q.cfg.speed100, ~s_q.cfg.speed100};
      end
      default: rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    s_d              = s_q;
    wr_fire          = 1'b0;
    rd_flags         = 1'b0;
    s_d.mdc_prev     = mdc;
    s_d.present_prev = line_energy_present;
    // the mode strap is caught once, the cycle after reset release
    if (!s_q.loaded) begin
      s_d.loaded = 1'b1;
      s_d.mode   = mode_strap;
    end
    case (s_q.ph)
      PH_PRE: begin
        if (rise) begin
          if (mdio_in) begin
            if (s_q.cnt != pvcr_pkg::PREAMBLE_LEN) begin
              s_d.cnt = s_q.cnt + 6'h01;
            end
          end else if (s_q.cnt == pvcr_pkg::PREAMBLE_LEN) begin
            s_d.ph  = PH_HDR;
            s_d.cnt = 6'h00;
          end else begin
            s_d.cnt = 6'h00;
          end
        end
      end
      PH_HDR: begin
        if (rise) begin
          s_d.hdr = hdr_in;
          s_d.cnt = s_q.cnt + 6'h01;
          if (s_q.cnt == pvcr_pkg::HDR_LAST) begin
            s_d.cnt = 6'h00;
            s_d.ph  = PH_PRE;
            // only frames carrying our station address are answered
            if (hdr_in[12] && hdr_in[9:5] == s_q.addr) begin
              if (hdr_in[11:10] == pvcr_pkg::OP_RD) begin
                s_d.ph    = PH_RD;
                s_d.rdata = rd_word;
                rd_flags  = hdr_in[4:0] == pvcr_pkg::REG_FLAGS;
              end else if (hdr_in[11:10] == pvcr_pkg::OP_WR) begin
                s_d.ph = PH_WR;
              end
            end
          end
        end
      end
      PH_RD: begin
        // first turnaround bit released, second driven low, then data
        if (fall) begin
          s_d.cnt = s_q.cnt + 6'h01;
          if (s_q.cnt == pvcr_pkg::RD_END) begin
            s_d.moe = 1'b0;
            s_d.ph  = PH_PRE;
            s_d.cnt = 6'h00;
          end else if (s_q.cnt == 6'h00) begin
            s_d.moe = 1'b0;
          end else if (s_q.cnt == 6'h01) begin
            s_d.moe = 1'b1;
            s_d.mdo = 1'b0;
          end else begin
            s_d.moe   = 1'b1;
            s_d.mdo   = s_q.rdata[15];
            s_d.rdata = {s_q.rdata[14:0], 1'b0};
          end
        end
      end
      PH_WR: begin
        if (rise) begin
          s_d.cnt   = s_q.cnt + 6'h01;
          s_d.wdata = wr_word;
          if (s_q.cnt == pvcr_pkg::WR_LAST) begin
            wr_fire = 1'b1;
            s_d.ph  = PH_PRE;
            s_d.cnt = 6'h00;
          end
        end
      end
      default: begin
        s_d.ph  = PH_PRE;
        s_d.cnt = 6'h00;
        s_d.moe = 1'b0;
      end
    endcase

    if (wr_fire) begin
      case (s_q.hdr[4:0])
        pvcr_pkg::REG_ENERGY: s_d.edpd = wr_word[pvcr_pkg::EDPD_BIT];
        pvcr_pkg::REG_STRAP: begin
          s_d.mode = wr_word[pvcr_pkg::MODE_LSB +: 3];
          s_d.addr = wr_word[pvcr_pkg::ADDR_LSB +: 5];
        end
        pvcr_pkg::REG_XOVER: begin
          s_d.ovr      = wr_word[pvcr_pkg::OVR_BIT];
          s_d.amdix    = wr_word[pvcr_pkg::AMDIX_BIT];
          s_d.mdix     = wr_word[pvcr_pkg::MDIX_BIT];
          s_d.pll_lock = wr_word[pvcr_pkg::PLL_BIT];
        end
        pvcr_pkg::REG_MASK: s_d.mask = wr_word[7:0];
        pvcr_pkg::REG_LINK: s_d.link_rsv = wr_word[pvcr_pkg::RSV_LSB +: 7];
        default: s_d.edpd = s_q.edpd;
      endcase
    end

    // mode, address and PLL hold are kept over soft reset
    if (soft_reset) begin
      s_d.edpd     = 1'b0;
      s_d.ovr      = 1'b0;
      s_d.amdix    = 1'b0;
      s_d.mdix     = 1'b0;
      s_d.mask     = pvcr_pkg::MASK_RST;
      s_d.link_rsv = pvcr_pkg::LINK_RSV_RST;
    end

    // strap chooses unless overridden; 15:13 all set is never written
    if (!s_q.ovr) begin
      s_d.xauto = crossover_strap_input;
      s_d.xswap = 1'b0;
    end else if (s_q.amdix) begin
      s_d.xauto = 1'b1;
      s_d.xswap = 1'b0;
    end else begin
      s_d.xauto = 1'b0;
      s_d.xswap = s_q.mdix;
    end

    s_d.cfg = '0;
    case (s_q.mode)
      pvcr_pkg::MODE_10F: begin
        s_d.cfg.full_duplex = 1'b1;
      end
      pvcr_pkg::MODE_100H: begin
        s_d.cfg.speed100  = 1'b1;
        s_d.cfg.crs_on_tx = 1'b1;
      end
      pvcr_pkg::MODE_100F: begin
        s_d.cfg.speed100    = 1'b1;
        s_d.cfg.full_duplex = 1'b1;
      end
      pvcr_pkg::MODE_AN_H, pvcr_pkg::MODE_REPT: begin
        s_d.cfg.autoneg_en = 1'b1;
        s_d.cfg.speed100   = 1'b1;
        s_d.cfg.adv        = pvcr_pkg::ADV_100H;
        s_d.cfg.repeater   = s_q.mode == pvcr_pkg::MODE_REPT;
        s_d.cfg.crs_on_tx  = s_q.mode == pvcr_pkg::MODE_AN_H;
      end
      pvcr_pkg::MODE_ALL: begin
        s_d.cfg.autoneg_en  = 1'b1;
        s_d.cfg.adv         = pvcr_pkg::ADV_ALL;
        s_d.cfg.speed100    = res_speed100;
        s_d.cfg.full_duplex = res_full_duplex;
        s_d.cfg.crs_on_tx   = ~res_full_duplex;
      end
      // 10 half, and the reserved code which is never programmed
      default: begin
        s_d.cfg.crs_on_tx = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q          <= '0;
      s_q.mode     <= pvcr_pkg::MODE_RST;
      s_q.addr     <= pvcr_pkg::ADDR_RST;
      s_q.mask     <= pvcr_pkg::MASK_RST;
      s_q.link_rsv <= pvcr_pkg::LINK_RSV_RST;
      s_q.ph       <= PH_PRE;
      // matches the timer's reset level so no false energy edge follows
      s_q.present_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign mdio_out                   = s_q.mdo;
  assign mdio_oe                    = s_q.moe;
  assign link_cfg                   = s_q.cfg;
  assign energy_detect_powerdown_en = s_q.edpd;
  assign station_address            = s_q.addr;
  assign auto_crossover_en          = s_q.xauto;
  assign pairs_swapped              = s_q.xswap;
  assign rx_pll_reference_lock      = s_q.pll_lock;
  assign phy_irq = |({flags, 1'b0} & s_q.mask);

  edpd_write_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    (wr_fire && !soft_reset && s_q.hdr[4:0] == pvcr_pkg::REG_ENERGY)
    |=> energy_detect_powerdown_en == $past(wr_word[pvcr_pkg::EDPD_BIT]))
    else $error("power-down enable not written");

  energy_hw_reset_a: assert property (@(posedge clk)
    disable iff (!rst_sync_q)
    !s_q.loaded |-> line_energy_present)
    else $error("energy status not set by hardware reset");

  station_match_a: assert property (@(posedge clk)
    disable iff (!rst_sync_q)
    (s_q.ph == PH_RD) |-> s_q.hdr[9:5] == s_q.addr)
    else $error("answered a foreign station address");

  mode_10f_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    ($past(s_q.mode) == pvcr_pkg::MODE_10F && s_q.loaded) |->
    (!link_cfg.autoneg_en && !link_cfg.speed100 && link_cfg.full_duplex))
    else $error("mode 001 decoded wrongly");

  mode_100f_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    ($past(s_q.mode) == pvcr_pkg::MODE_100F && s_q.loaded) |->
    (link_cfg.speed100 && link_cfg.full_duplex && !link_cfg.crs_on_tx))
    else $error("mode 011 decoded wrongly");

  mode_repeat_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    ($past(s_q.mode) == pvcr_pkg::MODE_REPT && s_q.loaded) |->
    (link_cfg.repeater && link_cfg.adv == 4'h4 && link_cfg.autoneg_en))
    else $error("repeater mode decoded wrongly");

  mode_all_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    ($past(s_q.mode) == pvcr_pkg::MODE_ALL && s_q.loaded) |->
    (link_cfg.adv == 4'hf && link_cfg.speed100 == $past(res_speed100)))
    else $error("all-capable mode decoded wrongly");

  manual_swap_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    ($past(s_q.ovr) && !$past(s_q.amdix)) |->
    (pairs_swapped == $past(s_q.mdix) && !auto_crossover_en))
    else $error("manual crossover not applied");

  strap_xover_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    (!$past(s_q.ovr) && s_q.loaded) |->
    (auto_crossover_en == $past(crossover_strap_input) && !pairs_swapped))
    else $error("crossover strap not followed");

  flag_clear_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    (rd_flags && set_vec == 7'h00) |=> flags == 7'h00)
    else $error("flags not cleared by read");

  irq_mask_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    (wr_fire && s_q.hdr[4:0] == pvcr_pkg::REG_MASK && !soft_reset &&
     wr_word[7:0] == 8'h00) |=> !phy_irq)
    else $error("masked flags still raise the interrupt");
endmodule : pvcr_regs

// ==== pvcr_mdio_master.sv ====
`timescale 1ns/10ps
module pvcr_mdio_master (
  input  wire logic   clk,     // system clock
  input  wire logic   mdio,    // resolved pin level
  output logic        mdc,     // mgmt clock, still between frames
  output logic        m_out,   // data driven
  output logic        m_oe,    // drive enable
  output logic [15:0] rd_data, // word sampled in the last frame
  output logic        rd_stb   // one-cycle read strobe
);
  logic [15:0] sh;
  initial begin
    {mdc, m_out, m_oe, rd_stb} = 4'h0;
    rd_data = 16'h0000;
    sh = 16'h0000;
  end
  // 8 clk per bit keeps mdc well under clk/4
  task automatic bit_t(input logic b, input logic oe);
    @(posedge clk);
    mdc <= 1'b0;
    m_out <= b;
    m_oe <= oe;
    repeat (4) @(posedge clk);
    sh <= {sh[14:0], mdio};
    mdc <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : bit_t
  task automatic frame(input logic [1:0] op, input logic [4:0] ad,
                       input logic [4:0] rg, input logic [15:0] wd);
    logic [13:0] hdr;
    hdr = {2'b01, op, ad, rg};
    repeat (32) bit_t(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) bit_t(hdr[i], 1'b1);
    if (op == pvcr_pkg::OP_WR) begin
      bit_t(1'b1, 1'b1);
      bit_t(1'b0, 1'b0);
      for (int i = 15; i >= 0; i--) bit_t(wd[i], 1'b1);
    end else begin
      repeat (18) bit_t(1'b0, 1'b0);
    end
    @(posedge clk);
    mdc <= 1'b0;
    m_oe <= 1'b0;
    rd_data <= sh;
    rd_stb <= (op == pvcr_pkg::OP_RD);
    @(posedge clk);
    rd_stb <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : frame
endmodule : pvcr_mdio_master

// ==== pvcr_regs_test.sv ====
`timescale 1ns/10ps
module pvcr_regs_test;
  localparam int EC = 20;
  logic clk = 1'b0, arst_n = 1'b0, soft_reset = 1'b0, xs = 1'b1;
  logic le = 1'b1, pol = 1'b1, nd = 1'b1, s100 = 1'b1, fd = 1'b0;
  logic [2:0] strap = 3'h7;
  pvcr_pkg::pvcr_events_t ev = '0;
  pvcr_pkg::pvcr_cfg_t cfg;
  logic mdc, mo, moe, so, soe, stb, mdio, pd, lep, ax, sw, pll, irq;
  logic [4:0] sa, na, ad = 5'h01;
  logic [5:0] evv;
  logic [15:0] rd, el, ec;
  logic [31:0] seed = 32'd46;
  logic [15:0] exp_q[$];
  logic [2:0] modes[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [18:0] xt[5] = '{{16'h0000, 3'b110}, {16'h0000, 3'b000},
    {16'h8000, 3'b100}, {16'hc000, 3'b010}, {16'ha410, 3'b101}};
  int fails = 0, num_checks = 0;
  assign mdio = soe ? so : (moe ? mo : 1'b1); // pull-up when released
  always #2 clk = ~clk;
  pvcr_regs #(.ENERGY_CYCLES(EC), .ENERGY_CNT_W(8)) dut (
    .clk(clk), .arst_n(arst_n), .soft_reset(soft_reset), .mdc(mdc),
    .mdio_in(mdio), .mdio_out(so), .mdio_oe(soe), .mode_strap(strap),
    .crossover_strap_input(xs), .line_energy(le),
    .rx_polarity_reversed(pol), .negotiation_done(nd),
    .res_speed100(s100), .res_full_duplex(fd), .events(ev),
    .link_cfg(cfg), .energy_detect_powerdown_en(pd),
    .line_energy_present(lep), .station_address(sa),
    .auto_crossover_en(ax), .pairs_swapped(sw),
    .rx_pll_reference_lock(pll), .phy_irq(irq));
  pvcr_mdio_master mgr (.clk(clk), .mdio(mdio), .mdc(mdc), .m_out(mo),
    .m_oe(moe), .rd_data(rd), .rd_stb(stb));
  function automatic logic [31:0] xs32(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs32
  function automatic logic [15:0] elink(input logic [2:0] m);
    logic sp, f;
    sp = (m inside {[3'h2:3'h5]}) | ((m == 3'h7) & s100);
    f = (m == 3'h1) | (m == 3'h3) | ((m == 3'h7) & fd);
    return {3'h0, nd & m[2], 7'h02, f, sp, ~sp, 2'h0};
  endfunction : elink
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] r, input logic [15:0] d);
    mgr.frame(pvcr_pkg::OP_WR, ad, r, d);
  endtask : wr
  task automatic rdx(input logic [4:0] r, input logic [15:0] e);
    exp_q.push_back(e);
    mgr.frame(pvcr_pkg::OP_RD, ad, r, 16'h0000);
  endtask : rdx
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc
  always @(posedge clk) begin
    if (stb === 1'b1) chk(rd, exp_q.pop_front());
  end
  task automatic results;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  initial begin : watchdog
    repeat (60000) @(posedge clk);
    fails++;
    results();
  end
  initial begin : main
    cyc(4);
    @(posedge clk);
    arst_n <= 1'b1;
    cyc(6);
    rdx(pvcr_pkg::REG_ENERGY, 16'h0002);
    rdx(pvcr_pkg::REG_STRAP, 16'h00e1);
    rdx(pvcr_pkg::REG_MASK, 16'h0000);
    rdx(pvcr_pkg::REG_XOVER, 16'h0010);
    rdx(5'h05, 16'h0000); // unmapped reads zero
    wr(pvcr_pkg::REG_LINK, 16'h0040);
    rdx(pvcr_pkg::REG_LINK, elink(3'h7));
    wr(pvcr_pkg::REG_ENERGY, 16'h2000);
    chk(16'(pd), 16'h0001);
    rdx(pvcr_pkg::REG_ENERGY, 16'h2002);
    // reserved mode 110 is never written
    foreach (modes[i]) begin
      seed = xs32(seed);
      {nd, s100, fd} <= seed[2:0];
      wr(pvcr_pkg::REG_STRAP, {8'h00, modes[i], 5'h01});
      el = elink(modes[i]);
      ec = {8'h00, modes[i][2], el[3], el[4], 5'h00};
      if (modes[i][2]) ec[4:1] = (modes[i] == 3'h7) ? 4'hf : 4'h4;
      ec[0] = modes[i] == 3'h5;
      chk(16'({cfg[8:2], cfg[0]}), ec);
      if (modes[i] == 3'h7) chk(16'(cfg.adv), 16'h000f);
      if (modes[i] inside {[3'h2:3'h5]})
        chk(16'(cfg.crs_on_tx), 16'(!modes[i][0]));
      rdx(pvcr_pkg::REG_LINK, elink(modes[i]));
    end
    seed = xs32(seed);
    na = seed[4:0] | 5'h02;
    pol <= seed[7];
    wr(pvcr_pkg::REG_STRAP, {8'h00, 3'h7, na});
    chk(16'(sa), 16'(na));
    rdx(pvcr_pkg::REG_STRAP, 16'hffff);
    ad = na;
    rdx(pvcr_pkg::REG_STRAP, {8'h00, 3'h7, na});
    // all three crossover bits set is never written
    foreach (xt[i]) begin
      xs <= xt[i][2];
      wr(pvcr_pkg::REG_XOVER, xt[i][18:3]);
      chk(16'({ax, sw}), 16'(xt[i][1:0]));
      chk(16'(pll), 16'(xt[i][13]));
      rdx(pvcr_pkg::REG_XOVER, (xt[i][18:3] & 16'he400) | {pol, 4'h0});
    end
    evv = seed[13:8] | 6'h01;
    ev <= evv;
    @(posedge clk);
    ev <= '0;
    cyc(2);
    chk(16'(irq), 16'h0000);
    wr(pvcr_pkg::REG_MASK, 16'h00ff);
    chk(16'(irq), 16'h0001);
    wr(pvcr_pkg::REG_MASK, 16'h0000);
    chk(16'(irq), 16'h0000);
    wr(pvcr_pkg::REG_MASK, 16'h007e);
    chk(16'(irq), 16'h0001);
    rdx(pvcr_pkg::REG_FLAGS, {9'h0, evv, 1'b0});
    chk(16'(irq), 16'h0000);
    rdx(pvcr_pkg::REG_FLAGS, 16'h0000);
    le <= 1'b0;
    cyc(EC - 2);
    chk(16'(lep), 16'h0001);
    cyc(5);
    chk(16'(lep), 16'h0000);
    rdx(pvcr_pkg::REG_ENERGY, 16'h2000);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    cyc(3);
    chk(16'(lep), 16'h0000);
    rdx(pvcr_pkg::REG_ENERGY, 16'h0000);
    rdx(pvcr_pkg::REG_MASK, 16'h0000);
    rdx(pvcr_pkg::REG_STRAP, {8'h00, 3'h7, na});
    le <= 1'b1;
    cyc(2);
    chk(16'(lep), 16'h0001);
    rdx(pvcr_pkg::REG_FLAGS, 16'h0080);
    le <= 1'b0;
    strap <= 3'h3;
    arst_n <= 1'b0;
    cyc(EC + 4);
    chk(16'(lep), 16'h0001);
    @(posedge clk);
    arst_n <= 1'b1;
    ad = 5'h01;
    cyc(6);
    rdx(pvcr_pkg::REG_STRAP, 16'h0061);
    results();
  end
endmodule : pvcr_regs_test
